// ---- design/omt_pkg.sv ----
// constants, encodings and frame layout of the four-to-one muxponder core
// assumes a single 50 MHz core clock; all users write omt_pkg::name
// What this block does
// - four 2.5 Gbps client streams are combined into one 10 Gbps trunk stream
// - each client rides its own container; four are multiplexed into one trunk frame
// - client overhead bytes pass through unchanged by default
// - when provisioned, regenerator section overhead is terminated, not forwarded
// - trunk overhead bytes carry termination and correction mode to the far end
// - correction check bytes sit inside the trunk frame
// - standard mode uses the block correction code
// - enhanced mode uses the stronger correction code
// - normally the trunk is timed from the shelf timing card clock
// - no holdover: a lost reference is never replaced by a stored estimate
// - with no card clock, switch hitlessly to lowest valid client clock, unless all clients failed since card clocks were lost
// - keep watching card clocks and return to one when it is valid
// - no card clock and no valid client: process no frames
// - one valid client recovered clock can be offered to the timing card
// - optionally squelch client output on trunk loss of signal or remote fault
// - on remote fault, unless squelched, insert multiplex section alarm signal into client outputs
// - correction off, standard or enhanced; trunk rate identical in all three
// - after reset standard correction is selected, enhanced off
// - on loss of communication or far-end loss, a setting picks alarm or squelch
package omt_pkg;
	localparam int CLI_N = 4;
	localparam int BYTE_W = 8;
	localparam int POS_W = 5;
	localparam logic [POS_W-1:0] POS_FAS = 5'h00;
	localparam logic [POS_W-1:0] POS_MODE = 5'h01;
	localparam logic [POS_W-1:0] POS_PAY = 5'h02;
	localparam logic [POS_W-1:0] POS_CHK = 5'h12;
	localparam logic [POS_W-1:0] POS_LAST = 5'h15;
	localparam logic [7:0] FAS_BYTE = 8'hF6;
	localparam logic [7:0] STUFF_BYTE = 8'h55;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [2:0] MODE_PAD = 3'h0;
	localparam int FIFO_DEPTH = 4;
	localparam int SYNC_W = 15;
	typedef enum logic [1:0] {
		FEC_OFF = 2'h0,
		FEC_RS = 2'h1,
		FEC_ENH = 2'h2
	} omt_fec_e;
	typedef enum logic [2:0] {
		SRC_CARD0 = 3'h0,
		SRC_CARD1 = 3'h1,
		SRC_CLI0 = 3'h2,
		SRC_CLI1 = 3'h3,
		SRC_CLI2 = 3'h4,
		SRC_CLI3 = 3'h5,
		SRC_NONE = 3'h6
	} omt_src_e;
endpackage

// ---- design/omt_fifo.sv ----
// small first-in first-out buffer between client mapping and trunk framing
// assumes one clock; depth is a power of two
`timescale 1ns/100ps
module omt_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk_in, // core clock
	input wire logic rst_in, // async reset, high
	input wire logic wr_valid_in, // write offered
	input wire logic [W-1:0] wr_data_in, // write word
	output logic wr_ready_out, // room for a word
	output logic rd_valid_out, // word present
	output logic [W-1:0] rd_data_out, // oldest word
	input wire logic rd_ready_in // drain taken
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire empty = (wp_q == rp_q);
	wire do_wr = wr_valid_in && !full;
	wire do_rd = rd_ready_in && !empty;
	assign wr_ready_out = !full;
	assign rd_valid_out = !empty;
	assign rd_data_out = mem_q[rp_q[AW-1:0]];
	always_ff @(posedge clk_in)
	begin
		if (do_wr)
			mem_q[wp_q[AW-1:0]] <= wr_data_in;
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (do_wr)
				wp_q <= wp_q + 1'b1;
			if (do_rd)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule

// ---- design/omt_mux.sv ----
// four-client muxponder core: timing selector, client mapping, trunk framer,
// correction check field and client output alarm policy
// assumes client bytes come from core-clock logic; status lines and the
// trunk clock arrive asynchronously and are synchronised here
`timescale 1ns/100ps
module omt_mux (
	input wire logic mclk_in, // 50 MHz core clock
	input wire logic rst_in, // async reset, high
	input wire logic [1:0] card_clk_ok_in, // timing card clocks present
	input wire logic [3:0] cli_los_in, // client loss of signal
	input wire logic [3:0] cli_lof_in, // client loss of frame
	input wire logic [31:0] cli_data_in, // client bytes, client n at [8n+7:8n]
	input wire logic [3:0] cli_oh_in, // byte is section overhead
	input wire logic [3:0] cli_valid_in, // client byte offered
	output logic [3:0] cli_ready_out, // client byte taken
	input wire logic trunk_clk_in, // trunk byte clock
	input wire logic trunk_los_in, // trunk receiver loss of signal
	input wire logic remote_fault_in, // remote fault indication
	input wire logic trunk_loc_in, // trunk loss of communication
	input wire logic far_los_in, // far-end loss of signal
	input wire logic [1:0] fec_mode_in, // correction mode to load
	input wire logic fec_load_in, // load correction mode
	input wire logic rs_term_in, // terminate section overhead
	input wire logic squelch_en_in, // squelch on los or remote fault
	input wire logic loc_ais_in, // loc/far los: 1 alarm, 0 squelch
	input wire logic [1:0] ref_sel_in, // client offered to card
	output logic [7:0] trunk_data_out, // trunk byte
	output logic trunk_frame_out, // first byte of trunk frame
	output logic [1:0] fec_mode_out, // active correction mode
	output logic [2:0] tsel_src_out, // timing source in use
	output logic tsel_change_out, // source changed, one cycle
	output logic frame_hold_out, // no frames processed
	output logic [1:0] ref_sel_out, // client offered to card
	output logic ref_valid_out, // offered clock is valid
	output logic cli_squelch_out, // client outputs squelched
	output logic cli_ais_out // alarm signal inserted in clients
);
	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [omt_pkg::SYNC_W-1:0] meta_q;
	logic [omt_pkg::SYNC_W-1:0] sync_q;
	logic s_tclk, s_flos, s_loc, s_rf, s_tlos;
	logic [3:0] s_lof, s_los;
	logic [1:0] s_card;
	logic tclk_q;
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_q <= '0;
			sync_q <= '0;
			tclk_q <= 1'b0;
		end
		else
		begin
			meta_q <= {trunk_clk_in, far_los_in, trunk_loc_in, remote_fault_in,
				trunk_los_in, cli_lof_in, cli_los_in, card_clk_ok_in};
			sync_q <= meta_q;
			tclk_q <= s_tclk;
		end
	end
	assign {s_tclk, s_flos, s_loc, s_rf, s_tlos, s_lof, s_los, s_card} = sync_q;
	wire tk_edge = s_tclk && !tclk_q;

	// ---------------------------------------------------------------
	// timing selector
	// ---------------------------------------------------------------
	wire [3:0] cli_ok = ~s_los & ~s_lof;
	omt_pkg::omt_src_e src_q, src_d;
	logic hold_q;
	logic starve_q;
	wire card_any = |s_card;
	function automatic logic cli_of(input omt_pkg::omt_src_e s, input logic [3:0] ok);
		logic r;
		r = 1'b0;
		case (s)
			omt_pkg::SRC_CLI0: r = ok[0];
			omt_pkg::SRC_CLI1: r = ok[1];
			omt_pkg::SRC_CLI2: r = ok[2];
			omt_pkg::SRC_CLI3: r = ok[3];
			default: r = 1'b0;
		endcase
		return r;
	endfunction
	// staying on a still-valid client avoids needless reference hops
	always_comb
	begin
		src_d = omt_pkg::SRC_NONE;
		if (s_card[0])
			src_d = omt_pkg::SRC_CARD0;
		else if (s_card[1])
			src_d = omt_pkg::SRC_CARD1;
		else if (starve_q)
			src_d = omt_pkg::SRC_NONE;
		else if (cli_of(src_q, cli_ok))
			src_d = src_q;
		else if (cli_ok[0])
			src_d = omt_pkg::SRC_CLI0;
		else if (cli_ok[1])
			src_d = omt_pkg::SRC_CLI1;
		else if (cli_ok[2])
			src_d = omt_pkg::SRC_CLI2;
		else if (cli_ok[3])
			src_d = omt_pkg::SRC_CLI3;
	end
	// no stored frequency: with nothing valid the source is simply none
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			src_q <= omt_pkg::SRC_NONE;
			hold_q <= 1'b1;
			starve_q <= 1'b0;
			tsel_change_out <= 1'b0;
		end
		else
		begin
			src_q <= src_d;
			hold_q <= (src_d == omt_pkg::SRC_NONE);
			// once starved, a returning client is not trusted; only a card clock ends the wait
			starve_q <= !card_any && (starve_q || !(|cli_ok));
			tsel_change_out <= (src_d != src_q);
		end
	end
	assign tsel_src_out = src_q;
	assign frame_hold_out = hold_q;

	// ---------------------------------------------------------------
	// reference offered to the timing card
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ref_sel_out <= 2'h0;
			ref_valid_out <= 1'b0;
		end
		else
		begin
			ref_sel_out <= ref_sel_in;
			ref_valid_out <= cli_ok[ref_sel_in];
		end
	end

	// ---------------------------------------------------------------
	// client mapping into the buffer
	// ---------------------------------------------------------------
	logic [1:0] slot_q;
	logic fifo_wr_ready, fifo_rd_valid;
	logic [7:0] fifo_rd_data;
	wire [7:0] slot_byte = cli_data_in[slot_q*8 +: 8];
	// a stalled client holds its slot so interleave order stays fixed
	wire slot_take = cli_valid_in[slot_q] && fifo_wr_ready && !hold_q;
	wire term_byte = rs_term_in && cli_oh_in[slot_q];
	wire [7:0] map_byte = term_byte ? omt_pkg::ZERO_BYTE : slot_byte;
	assign cli_ready_out = slot_take ? (4'h1 << slot_q) : 4'h0;
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			slot_q <= 2'h0;
		else if (slot_take)
			slot_q <= slot_q + 2'h1;
	end

	// ---------------------------------------------------------------
	// trunk framer
	// ---------------------------------------------------------------
	logic [omt_pkg::POS_W-1:0] pos_q;
	logic [7:0] chk_q;
	logic [1:0] fec_q;
	wire in_pay = (pos_q >= omt_pkg::POS_PAY) && (pos_q < omt_pkg::POS_CHK);
	wire fifo_pop = tk_edge && in_pay && !hold_q;
	wire [7:0] pay_byte = fifo_rd_valid ? fifo_rd_data : omt_pkg::STUFF_BYTE;
	// check field: xor accumulate in standard mode, rotate-add in enhanced;
	// the field length never changes so the line rate is fixed
	wire [7:0] chk_d = (fec_q == omt_pkg::FEC_RS) ? (chk_q ^ pay_byte) :
		(fec_q == omt_pkg::FEC_ENH) ? ({chk_q[6:0], chk_q[7]} + pay_byte) :
		omt_pkg::ZERO_BYTE;
	wire [7:0] mode_byte = {omt_pkg::MODE_PAD, rs_term_in, 2'h0, fec_q};
	wire [7:0] out_byte = (pos_q == omt_pkg::POS_FAS) ? omt_pkg::FAS_BYTE :
		(pos_q == omt_pkg::POS_MODE) ? mode_byte :
		in_pay ? pay_byte : chk_q;
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			fec_q <= omt_pkg::FEC_RS;
		else if (fec_load_in)
			fec_q <= fec_mode_in;
	end
	assign fec_mode_out = fec_q;
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pos_q <= omt_pkg::POS_FAS;
			chk_q <= omt_pkg::ZERO_BYTE;
			trunk_data_out <= omt_pkg::ZERO_BYTE;
			trunk_frame_out <= 1'b0;
		end
		else if (hold_q)
		begin
			pos_q <= omt_pkg::POS_FAS;
			chk_q <= omt_pkg::ZERO_BYTE;
			trunk_frame_out <= 1'b0;
		end
		else if (tk_edge)
		begin
			trunk_data_out <= out_byte;
			trunk_frame_out <= (pos_q == omt_pkg::POS_FAS);
			pos_q <= (pos_q == omt_pkg::POS_LAST) ? omt_pkg::POS_FAS : pos_q + 1'b1;
			if (pos_q == omt_pkg::POS_FAS)
				chk_q <= omt_pkg::ZERO_BYTE;
			else if (in_pay)
				chk_q <= chk_d;
		end
	end

	omt_fifo #(
		.W(omt_pkg::BYTE_W),
		.D(omt_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in(mclk_in),
		.rst_in(rst_in),
		.wr_valid_in(slot_take),
		.wr_data_in(map_byte),
		.wr_ready_out(fifo_wr_ready),
		.rd_valid_out(fifo_rd_valid),
		.rd_data_out(fifo_rd_data),
		.rd_ready_in(fifo_pop)
	);

	// ---------------------------------------------------------------
	// client output alarm policy
	// ---------------------------------------------------------------
	wire loc_any = s_loc || s_flos;
	wire sq_d = (squelch_en_in && (s_tlos || s_rf)) || (!loc_ais_in && loc_any);
	wire ais_d = !sq_d && (s_rf || (loc_ais_in && loc_any));
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cli_squelch_out <= 1'b0;
			cli_ais_out <= 1'b0;
		end
		else
		begin
			cli_squelch_out <= sq_d;
			cli_ais_out <= ais_d;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	property p_card;
		s_card[0] |=> tsel_src_out == omt_pkg::SRC_CARD0;
	endproperty
	a_card: assert property (p_card) else $error("card clock not used");
	property p_revert;
		(tsel_src_out >= omt_pkg::SRC_CLI0) && s_card[1] && !s_card[0]
			|=> tsel_src_out == omt_pkg::SRC_CARD1;
	endproperty
	a_revert: assert property (p_revert) else $error("no return to card");
	property p_lowest;
		(tsel_src_out == omt_pkg::SRC_NONE) && !s_card[0] && !s_card[1] && cli_ok[0] && !starve_q
			|=> tsel_src_out == omt_pkg::SRC_CLI0;
	endproperty
	a_lowest: assert property (p_lowest) else $error("not lowest client");
	property p_hold;
		(s_card == 2'h0) && (cli_ok == 4'h0) |=> frame_hold_out ##1 !trunk_frame_out;
	endproperty
	a_hold: assert property (p_hold) else $error("frames while holding");
	property p_wait;
		starve_q && (s_card == 2'h0) |=> tsel_src_out == omt_pkg::SRC_NONE;
	endproperty
	a_wait: assert property (p_wait) else $error("client used while waiting");
	property p_change;
		tsel_src_out != $past(tsel_src_out) |-> tsel_change_out;
	endproperty
	a_change: assert property (p_change) else $error("switch not reported");
	property p_fas;
		tk_edge && !hold_q && (pos_q == omt_pkg::POS_FAS)
			|=> trunk_frame_out && (trunk_data_out == omt_pkg::FAS_BYTE);
	endproperty
	a_fas: assert property (p_fas) else $error("frame start wrong");
	property p_term;
		slot_take && rs_term_in && cli_oh_in[slot_q] |-> map_byte == omt_pkg::ZERO_BYTE;
	endproperty
	a_term: assert property (p_term) else $error("overhead forwarded");
	property p_trans;
		slot_take && !rs_term_in |-> map_byte == $sampled(slot_byte);
	endproperty
	a_trans: assert property (p_trans) else $error("overhead altered");
	property p_squelch;
		squelch_en_in && s_tlos ##1 squelch_en_in |-> cli_squelch_out && !cli_ais_out;
	endproperty
	a_squelch: assert property (p_squelch) else $error("no squelch");
	property p_ais;
		s_rf && !squelch_en_in && !loc_any |=> cli_ais_out;
	endproperty
	a_ais: assert property (p_ais) else $error("no alarm insert");
	property p_valid;
		(s_los[0] || s_lof[0]) |=> tsel_src_out != omt_pkg::SRC_CLI0;
	endproperty
	a_valid: assert property (p_valid) else $error("bad client used");
endmodule

// ---- test/omt_far_end.sv ----
// far-end trunk model: byte clock and the fault levels reported from the far side
// assumes the bench starts and stops the clock between runs of frames
`timescale 1ns/100ps
module omt_far_end (
	input wire logic run_in, // far end is sending
	input wire logic [3:0] flt_in, // los, remote fault, loc, far los
	output logic trunk_clk_out, // byte clock, 160 ns
	output logic [3:0] flt_out // fault levels seen by the core
);
	// clock stands low while stalled, so the core can fill its buffer
	initial
	begin
		trunk_clk_out = 1'b0;
		#37;
		forever
		begin
			#80;
			trunk_clk_out = run_in ? ~trunk_clk_out : 1'b0;
		end
	end
	assign flt_out = flt_in;
endmodule

// ---- test/test_omt_mux.sv ----
// self-checking bench of the muxponder core
// assumes omt_mux, omt_fifo and omt_pkg compiled before it
`timescale 1ns/100ps
module test_omt_mux;
	logic mclk_in, rst_in, trunk_clk_in, fec_load_in, rs_term_in, squelch_en_in, loc_ais_in;
	logic feed, run, oh, trunk_frame_out, tsel_change_out, frame_hold_out, ref_valid_out;
	logic cli_squelch_out, cli_ais_out;
	logic [1:0] card_clk_ok_in, fec_mode_in, ref_sel_in, fec_mode_out, ref_sel_out;
	logic [3:0] cli_los_in, cli_lof_in, cli_oh_in, cli_valid_in, cli_ready_out, flt, flt_w;
	logic [31:0] cli_data_in;
	logic [7:0] trunk_data_out, pat, acc, acc_e;
	logic [7:0] fr [22];
	logic [7:0] al [5] = '{8'h1A, 8'h2A, 8'h21, 8'h45, 8'h82};
	logic [2:0] tsel_src_out, e;
	int errors, checks_done, pulses, taken, seed, i, k, x;
	assign cli_oh_in = {4{oh}};
	assign cli_valid_in = {4{feed}};
	assign cli_data_in = {4{pat}};
	omt_far_end far (.run_in(run), .flt_in(flt), .trunk_clk_out(trunk_clk_in), .flt_out(flt_w));
	omt_mux dut (.mclk_in(mclk_in), .rst_in(rst_in), .card_clk_ok_in(card_clk_ok_in),
		.cli_los_in(cli_los_in), .cli_lof_in(cli_lof_in), .cli_data_in(cli_data_in),
		.cli_oh_in(cli_oh_in), .cli_valid_in(cli_valid_in), .cli_ready_out(cli_ready_out),
		.trunk_clk_in(trunk_clk_in), .trunk_los_in(flt_w[0]), .remote_fault_in(flt_w[1]),
		.trunk_loc_in(flt_w[2]), .far_los_in(flt_w[3]), .fec_mode_in(fec_mode_in),
		.fec_load_in(fec_load_in), .rs_term_in(rs_term_in), .squelch_en_in(squelch_en_in),
		.loc_ais_in(loc_ais_in), .ref_sel_in(ref_sel_in), .trunk_data_out(trunk_data_out),
		.trunk_frame_out(trunk_frame_out), .fec_mode_out(fec_mode_out),
		.tsel_src_out(tsel_src_out), .tsel_change_out(tsel_change_out),
		.frame_hold_out(frame_hold_out), .ref_sel_out(ref_sel_out),
		.ref_valid_out(ref_valid_out), .cli_squelch_out(cli_squelch_out),
		.cli_ais_out(cli_ais_out));
	initial
	begin
		mclk_in = 1'b0;
		forever
			#10 mclk_in = ~mclk_in;
	end
	// each taken client byte moves the pattern on, so order and loss both show
	always @(posedge mclk_in)
		if ((|(cli_valid_in & cli_ready_out)) === 1'b1)
		begin
			taken++;
			pat <= #2 pat + 8'h01;
		end
	always @(posedge mclk_in)
		if (tsel_change_out === 1'b1)
			pulses++;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		checks_done++;
		if (got !== ex)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#2;
	endtask
	function automatic logic [2:0] exp_src(input logic [1:0] c, input logic [3:0] bad);
		if (c[0])
			return 3'h0;
		if (c[1])
			return 3'h1;
		for (int n = 0; n < 4; n++)
			if (!bad[n])
				return 3'(n + 2);
		return 3'h6;
	endfunction
	task automatic grab();
		k = 0;
		while (trunk_frame_out !== 1'b1 && k < 400)
		begin
			tick(1);
			k++;
		end
		chk("frame_start", 8'h01, {7'h0, trunk_frame_out});
		fr[0] = trunk_data_out;
		for (int j = 1; j < 22; j++)
		begin
			@(posedge trunk_clk_in);
			#120;
			fr[j] = trunk_data_out;
		end
	endtask
	initial
	begin
		#1_000_000;
		errors++;
		close_out();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'h4ea1;
		{rst_in, fec_load_in, rs_term_in, squelch_en_in, loc_ais_in, feed, run, oh} = 8'h80;
		{card_clk_ok_in, fec_mode_in, ref_sel_in, cli_los_in, cli_lof_in, flt} = '0;
		pat = 8'($random(seed));
		tick(2);
		chk("fec_reset", 8'h01, {6'h0, fec_mode_out});
		chk("src_reset", 8'h06, {5'h0, tsel_src_out});
		rst_in = 1'b0;
		for (i = 0; i < 8; i++)
		begin
			card_clk_ok_in = 2'h3;
			tick(6);
			chk("src_card", 8'h00, {5'h0, tsel_src_out});
			chk("hold_card", 8'h00, {7'h0, frame_hold_out});
			x = pulses;
			cli_los_in = (i == 0) ? 4'hF : 4'($random(seed));
			cli_lof_in = 4'($random(seed) & $random(seed));
			ref_sel_in = 2'($random(seed));
			card_clk_ok_in = 2'h0;
			tick(6);
			e = exp_src(2'h0, cli_los_in | cli_lof_in);
			chk("src_client", {5'h0, e}, {5'h0, tsel_src_out});
			chk("hold", {7'h0, e == 3'h6}, {7'h0, frame_hold_out});
			chk("change", 8'h01, 8'(pulses - x));
			chk("ref_valid", {7'h0, !(cli_los_in[ref_sel_in] | cli_lof_in[ref_sel_in])},
				{7'h0, ref_valid_out});
			chk("ref_sel", {6'h0, ref_sel_in}, {6'h0, ref_sel_out});
			if (i == 0)
			begin
				cli_los_in = 4'h0;
				tick(6);
				chk("src_wait", 8'h06, {5'h0, tsel_src_out});
				chk("hold_wait", 8'h01, {7'h0, frame_hold_out});
			end
			card_clk_ok_in = i[0] ? 2'h1 : 2'h2;
			tick(6);
			chk("src_back", {5'h0, exp_src(card_clk_ok_in, 4'hF)}, {5'h0, tsel_src_out});
		end
		$display("selector test done");
		card_clk_ok_in = 2'h3;
		{feed, run} = 2'h3;
		for (i = 0; i < 3; i++)
		begin
			fec_mode_in = 2'(i);
			rs_term_in = (i == 0);
			oh = rs_term_in;
			fec_load_in = 1'b1;
			tick(1);
			fec_load_in = 1'b0;
			tick(4);
			chk("fec_mode", 8'(i), {6'h0, fec_mode_out});
			grab();
			grab();
			chk("fas", 8'hF6, fr[0]);
			chk("mode_byte", {3'h0, rs_term_in, 2'h0, fec_mode_in}, fr[1]);
			acc = fr[2];
			acc_e = fr[2];
			for (int j = 3; j < 18; j++)
			begin
				acc ^= fr[j];
				acc_e = {acc_e[6:0], acc_e[7]} + fr[j];
				chk("payload", rs_term_in ? 8'h00 : fr[j - 1] + 8'h01, fr[j]);
			end
			for (int j = 18; j < 22; j++)
				chk("check", (i == 0) ? 8'h00 : (i == 1) ? acc : acc_e, fr[j]);
			@(posedge trunk_clk_in);
			#120;
			chk("frame_len", 8'h01, {7'h0, trunk_frame_out});
			tick(1);
		end
		$display("frame test done");
		// far end stalls: buffer must fill and then refuse
		feed = 1'b0;
		tick(100);
		run = 1'b0;
		tick(10);
		taken = 0;
		feed = 1'b1;
		tick(20);
		x = taken;
		tick(10);
		chk("fifo_fill", 8'h01, {7'h0, x >= omt_pkg::FIFO_DEPTH});
		chk("fifo_refuse", 8'(x), 8'(taken));
		feed = 1'b0;
		run = 1'b1;
		grab();
		chk("fifo_empty", 8'h55, fr[17]);
		$display("buffer test done");
		for (i = 0; i < 5; i++)
		begin
			{flt, squelch_en_in, loc_ais_in} = al[i][7:2];
			tick(6);
			chk("alarm", {6'h0, al[i][1:0]}, {6'h0, cli_squelch_out, cli_ais_out});
		end
		$display("alarm test done");
		close_out();
	end
endmodule
